// ===== design/rst_state_pkg.sv
/*
  package of constants for the reset-state and cause-flag block:
  register offsets, flag bit positions, reset values, vectors, event codes.
  assumes nothing of its surroundings.
*/
package rst_state_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] OFS_CAUSE = 4'h0;
  localparam logic [3:0] OFS_CTRL = 4'h1;
  localparam logic [3:0] OFS_PC_LOW = 4'h2;
  localparam logic [3:0] OFS_PC_HIGH = 4'h3;
  localparam logic [3:0] OFS_PC_UPPER = 4'h4;
  localparam logic [3:0] OFS_TOP_LOW = 4'h5;
  localparam logic [3:0] OFS_TOP_HIGH = 4'h6;
  localparam logic [3:0] OFS_TOP_UPPER = 4'h7;
  localparam logic [3:0] OFS_STACK_PTR = 4'h8;
  localparam logic [3:0] OFS_GENERAL = 4'h9;
  // cause flag register layout
  localparam int BIT_BROWNOUT = 0;
  localparam int BIT_POWERON = 1;
  localparam int BIT_POWERDOWN = 2;
  localparam int BIT_EXPIRY = 3;
  localparam int BIT_SOFT_RESET = 4;
  localparam int BIT_UNDERFLOW = 6;
  localparam int BIT_OVERFLOW = 7;
  // control register layout
  localparam int BIT_STACK_FAULT_EN = 0;
  localparam int BIT_HI_IRQ_EN = 1;
  localparam int BIT_LO_IRQ_EN = 2;
  // value after a power-on reset: power-on and brown-out flags low, the other three causes high
  localparam logic [7:0] CAUSE_POR_VALUE = 8'h1c;
  localparam logic [7:0] CTRL_RESET_VALUE = 8'h01;
  localparam logic [7:0] GENERAL_RESET_VALUE = 8'h00;
  localparam logic [20:0] PC_RESET = 21'h000000;
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [20:0] VEC_HIGH = 21'h000008;
  localparam logic [20:0] VEC_LOW = 21'h000018;
  localparam logic [4:0] STACK_PTR_RESET = 5'h00;
  localparam logic [4:0] STACK_PTR_FULL = 5'h1f;
  localparam int STACK_DEPTH = 31;
  // resolved event classes, ordered most severe first
  typedef enum logic [3:0] {
    EV_NONE, EV_POWERON, EV_BROWNOUT, EV_PIN_FULL, EV_PIN_RUN, EV_PIN_SLEEP,
    EV_WDT_RUN, EV_WDT_SLEEP, EV_OVERFLOW, EV_UNDERFLOW_RST, EV_UNDERFLOW_ERR,
    EV_SOFT_RESET, EV_IRQ_WAKE
  } event_t;
  typedef enum logic [1:0] {PM_FULL, PM_RUN, PM_IDLE, PM_SLEEP} power_mode_t;
endpackage

// ===== design/pin_sync.sv
/*
  two-stage synchroniser for one level from outside the clock domain.
  assumes the input is a slow level; the first stage is read only by the second.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  logic meta_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_r <= RESET_LEVEL;
      dout <= RESET_LEVEL;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule // pin_sync

// ===== design/rst_state.sv
/*
  reset-state and cause-flag logic: classifies each reset or wake-up event,
  updates the active-low cause flags and stack flags, chooses the resume
  address and pushes the return address on an interrupt wake-up.
  assumes one clock; reset-source pins are asynchronous and pass a synchroniser;
  core-side event strobes are one-cycle pulses on sys_clk.
*/
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ps
module rst_state (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic power_on_n,
  input wire logic brownout_n,
  input wire logic external_reset_pin,
  input wire logic wdt_expired,
  input wire logic soft_reset_op,
  input wire logic stack_push_full,
  input wire logic stack_pop_empty,
  input wire logic irq_wake,
  input wire logic irq_is_high,
  input wire logic [1:0] power_mode,
  input wire logic [20:0] core_pc,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic core_reset_r,
  output logic resume_r,
  output logic [20:0] resume_pc_r,
  output logic irq_flag_clear_r
);
  // ************************************************************
  // input synchronisation
  // ************************************************************
  logic por_s, brn_s, pin_s;
  pin_sync #(.RESET_LEVEL(1'b0)) u_por (
    .sys_clk(sys_clk), .rst(rst), .din(~power_on_n), .dout(por_s));
  pin_sync #(.RESET_LEVEL(1'b0)) u_brn (
    .sys_clk(sys_clk), .rst(rst), .din(~brownout_n), .dout(brn_s));
  pin_sync #(.RESET_LEVEL(1'b0)) u_pin (
    .sys_clk(sys_clk), .rst(rst), .din(~external_reset_pin), .dout(pin_s));

  // level pins become single events on their assertion edge
  logic por_d_r, brn_d_r, pin_d_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      por_d_r <= 1'b0;
      brn_d_r <= 1'b0;
      pin_d_r <= 1'b0;
    end else begin
      por_d_r <= por_s;
      brn_d_r <= brn_s;
      pin_d_r <= pin_s;
    end
  end
  logic por_ev, brn_ev, pin_ev;
  assign por_ev = por_s & ~por_d_r;
  assign brn_ev = brn_s & ~brn_d_r;
  assign pin_ev = pin_s & ~pin_d_r;

  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] cause_r, cause_nxt;
  logic [7:0] ctrl_r;
  logic [7:0] general_r;
  logic [20:0] top_r;
  logic [4:0] sp_r;
  logic stack_en, hi_en, lo_en;
  assign stack_en = ctrl_r[rst_state_pkg::BIT_STACK_FAULT_EN];
  assign hi_en = ctrl_r[rst_state_pkg::BIT_HI_IRQ_EN];
  assign lo_en = ctrl_r[rst_state_pkg::BIT_LO_IRQ_EN];
  logic sleeping;
  assign sleeping = (power_mode == 2'(rst_state_pkg::PM_IDLE)) |
                    (power_mode == 2'(rst_state_pkg::PM_SLEEP));

  // ************************************************************
  // event classification
  // ************************************************************
  rst_state_pkg::event_t ev;
  always_comb begin
    ev = rst_state_pkg::EV_NONE;
    if (por_ev) begin
      ev = rst_state_pkg::EV_POWERON;
    end else if (brn_ev) begin
      ev = rst_state_pkg::EV_BROWNOUT;
    end else if (pin_ev) begin
      if (power_mode == 2'(rst_state_pkg::PM_FULL)) begin
        ev = rst_state_pkg::EV_PIN_FULL;
      end else if (sleeping) begin
        ev = rst_state_pkg::EV_PIN_SLEEP;
      end else begin
        ev = rst_state_pkg::EV_PIN_RUN;
      end
    end else if (wdt_expired) begin
      ev = sleeping ? rst_state_pkg::EV_WDT_SLEEP : rst_state_pkg::EV_WDT_RUN;
    end else if (stack_push_full && stack_en) begin
      ev = rst_state_pkg::EV_OVERFLOW;
    end else if (stack_pop_empty) begin
      ev = stack_en ? rst_state_pkg::EV_UNDERFLOW_RST : rst_state_pkg::EV_UNDERFLOW_ERR;
    end else if (soft_reset_op) begin
      ev = rst_state_pkg::EV_SOFT_RESET;
    end else if (irq_wake && sleeping) begin
      ev = rst_state_pkg::EV_IRQ_WAKE;
    end
  end

  // ************************************************************
  // cause flag update
  // ************************************************************
  logic [7:0] cause_sw;
  always_comb begin
    // software write first so that hardware events override it
    cause_sw = cause_r;
    if (reg_wr && reg_addr == rst_state_pkg::OFS_CAUSE) begin
      cause_sw = {reg_wdata[7:6], 1'b0, reg_wdata[4:0]};
    end
    cause_nxt = cause_sw;
    unique case (ev)
      rst_state_pkg::EV_POWERON: cause_nxt = rst_state_pkg::CAUSE_POR_VALUE;
      rst_state_pkg::EV_BROWNOUT: begin
        cause_nxt[rst_state_pkg::BIT_SOFT_RESET] = 1'b1;
        cause_nxt[rst_state_pkg::BIT_EXPIRY] = 1'b1;
        cause_nxt[rst_state_pkg::BIT_POWERDOWN] = 1'b1;
        cause_nxt[rst_state_pkg::BIT_BROWNOUT] = 1'b0;
      end
      rst_state_pkg::EV_PIN_FULL: cause_nxt = cause_sw;
      rst_state_pkg::EV_PIN_RUN: cause_nxt[rst_state_pkg::BIT_EXPIRY] = 1'b1;
      rst_state_pkg::EV_PIN_SLEEP: begin
        cause_nxt[rst_state_pkg::BIT_EXPIRY] = 1'b1;
        cause_nxt[rst_state_pkg::BIT_POWERDOWN] = 1'b0;
      end
      rst_state_pkg::EV_WDT_RUN: cause_nxt[rst_state_pkg::BIT_EXPIRY] = 1'b0;
      rst_state_pkg::EV_WDT_SLEEP: begin
        cause_nxt[rst_state_pkg::BIT_EXPIRY] = 1'b0;
        cause_nxt[rst_state_pkg::BIT_POWERDOWN] = 1'b0;
      end
      rst_state_pkg::EV_OVERFLOW: cause_nxt[rst_state_pkg::BIT_OVERFLOW] = 1'b1;
      rst_state_pkg::EV_UNDERFLOW_RST: cause_nxt[rst_state_pkg::BIT_UNDERFLOW] = 1'b1;
      rst_state_pkg::EV_UNDERFLOW_ERR: cause_nxt[rst_state_pkg::BIT_UNDERFLOW] = 1'b1;
      rst_state_pkg::EV_SOFT_RESET: cause_nxt[rst_state_pkg::BIT_SOFT_RESET] = 1'b0;
      rst_state_pkg::EV_IRQ_WAKE: cause_nxt[rst_state_pkg::BIT_POWERDOWN] = 1'b0;
      default: cause_nxt = cause_sw;
    endcase
  end

  // hardware only ever drives the power-on flag low
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cause_r <= rst_state_pkg::CAUSE_POR_VALUE;
    end else begin
      cause_r <= cause_nxt;
    end
  end

  // ************************************************************
  // reset categories and resume address
  // ************************************************************
  logic is_hard_reset, is_full_reset, is_wake;
  always_comb begin
    is_full_reset = (ev == rst_state_pkg::EV_POWERON) | (ev == rst_state_pkg::EV_BROWNOUT);
    is_hard_reset = is_full_reset |
                    (ev == rst_state_pkg::EV_PIN_FULL) | (ev == rst_state_pkg::EV_PIN_RUN) |
                    (ev == rst_state_pkg::EV_PIN_SLEEP) | (ev == rst_state_pkg::EV_WDT_RUN) |
                    (ev == rst_state_pkg::EV_OVERFLOW) |
                    (ev == rst_state_pkg::EV_UNDERFLOW_RST) |
                    (ev == rst_state_pkg::EV_SOFT_RESET);
    is_wake = (ev == rst_state_pkg::EV_WDT_SLEEP) | (ev == rst_state_pkg::EV_IRQ_WAKE);
  end

  logic vector_wake;
  assign vector_wake = (ev == rst_state_pkg::EV_IRQ_WAKE) &&
                       (irq_is_high ? hi_en : lo_en);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      core_reset_r <= 1'b0;
      resume_r <= 1'b0;
      resume_pc_r <= rst_state_pkg::PC_RESET;
    end else begin
      core_reset_r <= is_hard_reset;
      resume_r <= is_hard_reset | is_wake;
      if (is_hard_reset) begin
        resume_pc_r <= rst_state_pkg::PC_RESET;
      end else if (vector_wake) begin
        resume_pc_r <= irq_is_high ? rst_state_pkg::VEC_HIGH : rst_state_pkg::VEC_LOW;
      end else if (is_wake) begin
        resume_pc_r <= core_pc + rst_state_pkg::PC_STEP;
      end
    end
  end

  // irq_flag_clear_r is held low, so the core is never told to clear any source's flag
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_flag_clear_r <= 1'b0;
    end else begin
      irq_flag_clear_r <= 1'b0;
    end
  end

  // ************************************************************
  // stack snapshot, control and general registers
  // ************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      top_r <= rst_state_pkg::PC_RESET;
      sp_r <= rst_state_pkg::STACK_PTR_RESET;
    end else if (is_hard_reset) begin
      top_r <= rst_state_pkg::PC_RESET;
      sp_r <= rst_state_pkg::STACK_PTR_RESET;
    end else if (vector_wake) begin
      top_r <= core_pc;
      if (sp_r != rst_state_pkg::STACK_PTR_FULL) begin
        sp_r <= sp_r + 5'h01;
      end
    end else if (reg_wr && reg_addr == rst_state_pkg::OFS_STACK_PTR) begin
      sp_r <= reg_wdata[4:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= rst_state_pkg::CTRL_RESET_VALUE;
    end else if (is_hard_reset) begin
      // interrupt enables go to zero, the fault enable is a fuse-like setting
      ctrl_r <= {5'h00, 2'b00, ctrl_r[rst_state_pkg::BIT_STACK_FAULT_EN]};
    end else if (reg_wr && reg_addr == rst_state_pkg::OFS_CTRL) begin
      ctrl_r <= {5'h00, reg_wdata[2:0]};
    end
  end

  // stands for the bulk of registers: kept across every reset but power-on
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      general_r <= rst_state_pkg::GENERAL_RESET_VALUE;
    end else if (ev == rst_state_pkg::EV_POWERON) begin
      general_r <= rst_state_pkg::GENERAL_RESET_VALUE;
    end else if (reg_wr && reg_addr == rst_state_pkg::OFS_GENERAL) begin
      general_r <= reg_wdata;
    end
  end

  // ************************************************************
  // read port
  // ************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        rst_state_pkg::OFS_CAUSE: reg_rdata <= cause_r;
        rst_state_pkg::OFS_CTRL: reg_rdata <= ctrl_r;
        rst_state_pkg::OFS_PC_LOW: reg_rdata <= resume_pc_r[7:0];
        rst_state_pkg::OFS_PC_HIGH: reg_rdata <= resume_pc_r[15:8];
        rst_state_pkg::OFS_PC_UPPER: reg_rdata <= {3'h0, resume_pc_r[20:16]};
        rst_state_pkg::OFS_TOP_LOW: reg_rdata <= top_r[7:0];
        rst_state_pkg::OFS_TOP_HIGH: reg_rdata <= top_r[15:8];
        rst_state_pkg::OFS_TOP_UPPER: reg_rdata <= {3'h0, top_r[20:16]};
        rst_state_pkg::OFS_STACK_PTR: reg_rdata <= {3'h0, sp_r};
        rst_state_pkg::OFS_GENERAL: reg_rdata <= general_r;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  AST_POR_PATTERN: assert property (@(posedge sys_clk) disable iff (rst)
    por_ev |=> cause_r == rst_state_pkg::CAUSE_POR_VALUE && resume_pc_r == 21'h000000)
    else $error("power-on flag pattern wrong");
  AST_BROWN_KEEPS_POR: assert property (@(posedge sys_clk) disable iff (rst)
    (!por_ev && brn_ev) |=> !cause_r[0] && cause_r[1] == $past(cause_r[1]))
    else $error("brown-out pattern wrong");
  AST_POR_NEVER_SET: assert property (@(posedge sys_clk) disable iff (rst)
    (!cause_r[1] && !(reg_wr && reg_addr == 4'h0)) |=> !cause_r[1])
    else $error("power-on flag set by hardware");
  AST_WDT_SLEEP: assert property (@(posedge sys_clk) disable iff (rst)
    (ev == rst_state_pkg::EV_WDT_SLEEP) |=> !core_reset_r && resume_r &&
      resume_pc_r == $past(core_pc) + 21'h000002 && cause_r[3:2] == 2'b00)
    else $error("watchdog wake wrong");
  AST_WDT_RUN: assert property (@(posedge sys_clk) disable iff (rst)
    (ev == rst_state_pkg::EV_WDT_RUN) |=> core_reset_r && !cause_r[3])
    else $error("watchdog reset wrong");
  AST_PIN_SLEEP: assert property (@(posedge sys_clk) disable iff (rst)
    (ev == rst_state_pkg::EV_PIN_SLEEP) |=> cause_r[3] && !cause_r[2] && core_reset_r)
    else $error("pin reset in sleep wrong");
  AST_UNF_NO_RESET: assert property (@(posedge sys_clk) disable iff (rst)
    (ev == rst_state_pkg::EV_UNDERFLOW_ERR) |=> !core_reset_r && cause_r[6])
    else $error("underflow without enable reset");
  AST_OVF_RESET: assert property (@(posedge sys_clk) disable iff (rst)
    (ev == rst_state_pkg::EV_OVERFLOW) |=> core_reset_r && cause_r[7])
    else $error("overflow reset wrong");
  AST_IRQ_VECTOR: assert property (@(posedge sys_clk) disable iff (rst)
    (vector_wake && irq_is_high) |=> resume_pc_r == 21'h000008 && top_r == $past(core_pc))
    else $error("interrupt vector wrong");
  AST_SOFT_RESET: assert property (@(posedge sys_clk) disable iff (rst)
    (ev == rst_state_pkg::EV_SOFT_RESET) |=> !cause_r[4] && cause_r[3:0] == $past(cause_r[3:0]))
    else $error("reset instruction flags wrong");
  AST_PIN_RUN: assert property (@(posedge sys_clk) disable iff (rst)
    (ev == rst_state_pkg::EV_PIN_RUN) |=> core_reset_r && cause_r[3] && resume_pc_r == 21'h000000)
    else $error("pin reset in run wrong");
  AST_PIN_FULL: assert property (@(posedge sys_clk) disable iff (rst)
    (ev == rst_state_pkg::EV_PIN_FULL) && !(reg_wr && reg_addr == rst_state_pkg::OFS_CAUSE)
      |=> core_reset_r && cause_r == $past(cause_r))
    else $error("pin reset at full power changed flags");
  AST_UNF_RESET: assert property (@(posedge sys_clk) disable iff (rst)
    (ev == rst_state_pkg::EV_UNDERFLOW_RST) |=> core_reset_r && cause_r[6])
    else $error("underflow with enable did not reset");
  AST_IRQ_WAKE: assert property (@(posedge sys_clk) disable iff (rst)
    (ev == rst_state_pkg::EV_IRQ_WAKE) |=> resume_r && !core_reset_r && !cause_r[2])
    else $error("interrupt wake wrong");
  AST_IRQ_PUSH: assert property (@(posedge sys_clk) disable iff (rst)
    (vector_wake && sp_r != rst_state_pkg::STACK_PTR_FULL) |=> sp_r == $past(sp_r) + 5'h01)
    else $error("return stack pointer not advanced");
  AST_CTRL_WAKE: assert property (@(posedge sys_clk) disable iff (rst)
    (is_wake && !(reg_wr && reg_addr == rst_state_pkg::OFS_CTRL)) |=> ctrl_r == $past(ctrl_r))
    else $error("wake-up changed interrupt control");
endmodule // rst_state

// ===== verif/evt_src_model.sv
/*
  model of the processor core and the reset sources that face the reset-state block.
  assumes fire() is called right after a rising edge of sys_clk.
*/
`timescale 1ns/1ps
module evt_src_model #(
  parameter logic [20:0] PC_VAL = 21'h000100
) (
  input wire logic sys_clk,
  output logic power_on_n,
  output logic brownout_n,
  output logic external_reset_pin,
  output logic wdt_expired,
  output logic soft_reset_op,
  output logic stack_push_full,
  output logic stack_pop_empty,
  output logic irq_wake,
  output logic irq_is_high,
  output logic [1:0] power_mode,
  output logic [20:0] core_pc
);
  // ***************************************************
  // idle levels and one event at a time
  // ***************************************************
  assign core_pc = PC_VAL;
  initial begin
    {power_on_n, brownout_n, external_reset_pin} = 3'h7;
    {wdt_expired, soft_reset_op, stack_push_full, stack_pop_empty, irq_wake} = 5'h00;
    irq_is_high = 1'b0;
    power_mode = 2'h0;
  end
  // pins stay low for six cycles so the synchroniser sees a clean level
  // pin_too drops the external pin beside a non-pin event, for coincident sources
  task automatic fire(input rst_state_pkg::event_t ev, input logic [1:0] m, input logic hi,
                      input logic pin_too);
    power_mode <= m;
    irq_is_high <= hi;
    if (pin_too) external_reset_pin <= 1'b0;
    case (ev)
      rst_state_pkg::EV_POWERON: power_on_n <= 1'b0;
      rst_state_pkg::EV_BROWNOUT: brownout_n <= 1'b0;
      rst_state_pkg::EV_PIN_FULL, rst_state_pkg::EV_PIN_RUN,
      rst_state_pkg::EV_PIN_SLEEP: external_reset_pin <= 1'b0;
      rst_state_pkg::EV_WDT_RUN, rst_state_pkg::EV_WDT_SLEEP: wdt_expired <= 1'b1;
      rst_state_pkg::EV_OVERFLOW: stack_push_full <= 1'b1;
      rst_state_pkg::EV_SOFT_RESET: soft_reset_op <= 1'b1;
      rst_state_pkg::EV_IRQ_WAKE: irq_wake <= 1'b1;
      default: stack_pop_empty <= 1'b1;
    endcase
    @(posedge sys_clk);
    {wdt_expired, soft_reset_op, stack_push_full, stack_pop_empty, irq_wake} <= 5'h00;
    repeat (5) @(posedge sys_clk);
    {power_on_n, brownout_n, external_reset_pin} <= 3'h7;
  endtask
endmodule // evt_src_model

// ===== verif/rst_state_tb_top.sv
/*
  self-checking bench for the reset-state block: event table, then vectors and odd cases.
  assumes the design files and evt_src_model are compiled first.
*/
`timescale 1ns/1ps
module rst_state_tb_top;
  localparam logic [20:0] PC_VAL = 21'h01a3c4;
  localparam logic [20:0] PC_NXT = PC_VAL + 21'h000002;
  typedef struct packed {
    rst_state_pkg::event_t ev;
    logic [1:0] mode;
    logic [7:0] start;
    logic [7:0] cause;
    logic rs;
    logic rm;
    logic [20:0] pc;
  } row_t;
  logic sys_clk, rst, power_on_n, brownout_n, external_reset_pin, wdt_expired, soft_reset_op;
  logic stack_push_full, stack_pop_empty, irq_wake, irq_is_high, reg_wr, reg_rd;
  logic core_reset_r, resume_r, irq_flag_clear_r, got_rs, got_rm;
  logic [1:0] power_mode;
  logic [20:0] core_pc, resume_pc_r, got_pc;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  int failures = 0;
  int n_checks = 0;
  // start value written by software first; mode 0 full, 1 run, 2 idle, 3 sleep
  row_t rows [15] = '{
    '{rst_state_pkg::EV_WDT_SLEEP, 2'h3, 8'h1f, 8'h13, 1'b0, 1'b1, PC_NXT},
    '{rst_state_pkg::EV_WDT_SLEEP, 2'h2, 8'h1f, 8'h13, 1'b0, 1'b1, PC_NXT},
    '{rst_state_pkg::EV_WDT_RUN, 2'h0, 8'h1f, 8'h17, 1'b1, 1'b1, 21'h0},
    '{rst_state_pkg::EV_WDT_RUN, 2'h1, 8'h1f, 8'h17, 1'b1, 1'b1, 21'h0},
    '{rst_state_pkg::EV_PIN_FULL, 2'h0, 8'h17, 8'h17, 1'b1, 1'b1, 21'h0},
    '{rst_state_pkg::EV_PIN_RUN, 2'h1, 8'h17, 8'h1f, 1'b1, 1'b1, 21'h0},
    '{rst_state_pkg::EV_PIN_SLEEP, 2'h2, 8'h17, 8'h1b, 1'b1, 1'b1, 21'h0},
    '{rst_state_pkg::EV_PIN_SLEEP, 2'h3, 8'h17, 8'h1b, 1'b1, 1'b1, 21'h0},
    '{rst_state_pkg::EV_SOFT_RESET, 2'h0, 8'h1f, 8'h0f, 1'b1, 1'b1, 21'h0},
    '{rst_state_pkg::EV_IRQ_WAKE, 2'h3, 8'h1f, 8'h1b, 1'b0, 1'b1, PC_NXT},
    '{rst_state_pkg::EV_IRQ_WAKE, 2'h0, 8'h1f, 8'h1f, 1'b0, 1'b0, 21'h0},
    '{rst_state_pkg::EV_OVERFLOW, 2'h0, 8'h1f, 8'h9f, 1'b1, 1'b1, 21'h0},
    '{rst_state_pkg::EV_POWERON, 2'h0, 8'h9f, 8'h1c, 1'b1, 1'b1, 21'h0},
    '{rst_state_pkg::EV_UNDERFLOW_RST, 2'h0, 8'h1f, 8'h5f, 1'b1, 1'b1, 21'h0},
    // brown-out reads as flag low beside a software-set power-on flag
    '{rst_state_pkg::EV_BROWNOUT, 2'h0, 8'h5f, 8'h5e, 1'b1, 1'b1, 21'h0}
  };

  rst_state i_dut (.sys_clk, .rst, .power_on_n, .brownout_n, .external_reset_pin,
    .wdt_expired, .soft_reset_op, .stack_push_full, .stack_pop_empty, .irq_wake,
    .irq_is_high, .power_mode, .core_pc, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .core_reset_r, .resume_r, .resume_pc_r, .irq_flag_clear_r);
  evt_src_model #(.PC_VAL(PC_VAL)) i_src (.sys_clk, .power_on_n, .brownout_n,
    .external_reset_pin, .wdt_expired, .soft_reset_op, .stack_push_full, .stack_pop_empty,
    .irq_wake, .irq_is_high, .power_mode, .core_pc);

  // ***************************************************
  // bus cycles and comparisons
  // ***************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // every task starts and ends right after a rising edge
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge sys_clk);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk({24'h0, v}, {24'h0, exp});
  endtask
  // pin events pass a synchroniser, so the answer is searched for over eight cycles
  task automatic observe();
    got_rs = 1'b0;
    got_rm = 1'b0;
    got_pc = '0;
    repeat (8) begin
      @(posedge sys_clk);
      #1;
      chk({31'h0, irq_flag_clear_r}, 32'h0);
      if (core_reset_r === 1'b1) got_rs = 1'b1;
      if (resume_r === 1'b1) begin
        got_rm = 1'b1;
        got_pc = resume_pc_r;
      end
    end
  endtask
  task automatic run_ev(input rst_state_pkg::event_t ev, input logic [1:0] m, input logic hi);
    fork
      i_src.fire(ev, m, hi, 1'b0);
      observe();
    join
    @(posedge sys_clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d, failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ***************************************************
  // clock, watchdog and test sequence
  // ***************************************************
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    #100000;
    failures++;
    print_verdict();
  end
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rdc(rst_state_pkg::OFS_CAUSE, 8'h1c);
    rdc(rst_state_pkg::OFS_CTRL, 8'h01);
    wr(4'hc, 8'hff);
    rdc(4'hc, 8'h00);
    wr(rst_state_pkg::OFS_GENERAL, 8'ha5);
    run_ev(rst_state_pkg::EV_PIN_FULL, 2'h0, 1'b0);
    rdc(rst_state_pkg::OFS_GENERAL, 8'ha5);
    foreach (rows[i]) begin
      wr(rst_state_pkg::OFS_CAUSE, rows[i].start);
      run_ev(rows[i].ev, rows[i].mode, 1'b0);
      chk({31'h0, got_rs}, {31'h0, rows[i].rs});
      chk({31'h0, got_rm}, {31'h0, rows[i].rm});
      if (rows[i].rm === 1'b1) chk({11'h0, got_pc}, {11'h0, rows[i].pc});
      rdc(rst_state_pkg::OFS_CAUSE, rows[i].cause);
    end
    // wake with each global enable: vector taken, return address pushed
    for (int h = 1; h >= 0; h--) begin
      wr(rst_state_pkg::OFS_CTRL, (h == 1) ? 8'h03 : 8'h05);
      wr(rst_state_pkg::OFS_CAUSE, 8'h1f);
      rd(rst_state_pkg::OFS_STACK_PTR, d);
      run_ev(rst_state_pkg::EV_IRQ_WAKE, 2'h3, h[0]);
      chk({31'h0, got_rs}, 32'h0);
      chk({11'h0, got_pc}, (h == 1) ? 32'h000008 : 32'h000018);
      rdc(rst_state_pkg::OFS_TOP_LOW, PC_VAL[7:0]);
      rdc(rst_state_pkg::OFS_TOP_HIGH, PC_VAL[15:8]);
      rdc(rst_state_pkg::OFS_TOP_UPPER, {3'h0, PC_VAL[20:16]});
      rdc(rst_state_pkg::OFS_STACK_PTR, d + 8'h01);
      rdc(rst_state_pkg::OFS_CAUSE, 8'h1b);
      rdc(rst_state_pkg::OFS_CTRL, (h == 1) ? 8'h03 : 8'h05);
    end
    wr(rst_state_pkg::OFS_GENERAL, 8'h3c);
    run_ev(rst_state_pkg::EV_WDT_SLEEP, 2'h3, 1'b0);
    rdc(rst_state_pkg::OFS_GENERAL, 8'h3c);
    // underflow with the fault reset disabled only records the flag
    wr(rst_state_pkg::OFS_CTRL, 8'h00);
    wr(rst_state_pkg::OFS_CAUSE, 8'h1f);
    run_ev(rst_state_pkg::EV_UNDERFLOW_ERR, 2'h0, 1'b0);
    chk({31'h0, got_rs}, 32'h0);
    rdc(rst_state_pkg::OFS_CAUSE, 8'h5f);
    // power-on and pin reset in one cycle: the power-on pattern must win
    wr(rst_state_pkg::OFS_CAUSE, 8'h1f);
    fork
      i_src.fire(rst_state_pkg::EV_POWERON, 2'h1, 1'b0, 1'b1);
      observe();
    join
    @(posedge sys_clk);
    chk({31'h0, got_rs}, 32'h1);
    rdc(rst_state_pkg::OFS_CAUSE, 8'h1c);
    // reset in mid-run brings back the values after power-on
    wr(rst_state_pkg::OFS_CAUSE, 8'hff);
    wr(rst_state_pkg::OFS_STACK_PTR, 8'h07);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rdc(rst_state_pkg::OFS_CAUSE, 8'h1c);
    rdc(rst_state_pkg::OFS_CTRL, 8'h01);
    rdc(rst_state_pkg::OFS_STACK_PTR, 8'h00);
    print_verdict();
  end
endmodule // rst_state_tb_top
